// File: design/fbc_defines.svh
`ifndef FBC_DEFINES_SVH
`define FBC_DEFINES_SVH

`define FBC_WIDTH        4
`define FBC_ZERO         4'h0
`define FBC_BCD_MAX      4'h9
`define FBC_BIN_MAX      4'hF
`define FBC_MAX_FREQ_MHZ 10
`define FBC_CLK_FREQ_MHZ 25
// Least clk cycles between strobe falling edges at the top strobe rate
`define FBC_MIN_STROBE_CYC ((`FBC_CLK_FREQ_MHZ + `FBC_MAX_FREQ_MHZ - 1) / `FBC_MAX_FREQ_MHZ)

`endif

// File: design/fbc_pkg.sv
package fbc_pkg;
	typedef enum logic [1:0] {
		FBC_BIN_UP,
		FBC_BIN_DOWN,
		FBC_BCD_UP,
		FBC_BCD_DOWN
	} fbc_count_mode_t;
endpackage

// File: design/fbc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fbc_if;
	logic [3:0] presetData;
	logic       presetSel;
	logic       loadStrobe;
	logic       countQual;
	logic       countStrobe;
	logic       shiftSel;
	logic       serialIn;
	logic [1:0] countMode;
	logic       erase;
	logic [3:0] count;

	modport dev (
		input  presetData, presetSel, loadStrobe, countQual, countStrobe,
		input  shiftSel, serialIn, countMode, erase,
		output count
	);
	modport ctl (
		output presetData, presetSel, loadStrobe, countQual, countStrobe,
		output shiftSel, serialIn, countMode, erase,
		input  count
	);
endinterface
`default_nettype wire

// File: design/fbc_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "fbc_defines.svh"
module fbc_counter #(
	parameter int WIDTH = `FBC_WIDTH
) (
	// System
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clkEn,
	// Link
	fbc_if.dev        link
);
	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] setIn;
	logic             loadPrev_q;
	logic             countPrev_q;
	logic             loadFall;
	logic             countFall;
	logic [WIDTH-1:0] cntNext;
	logic             stageTick;
	fbc_pkg::fbc_count_mode_t mode;

	assign mode = fbc_pkg::fbc_count_mode_t'(link.countMode);

	// ********************************
	// Strobe edges
	// ********************************
	// Strobes arrive as synchronous levels; 25 MHz sampling covers 10 MHz strobes
	always_ff @(posedge clk) begin
		if (rst) begin
			loadPrev_q  <= 1'b0;
			countPrev_q <= 1'b0;
		end else if (clkEn) begin
			loadPrev_q  <= link.loadStrobe;
			countPrev_q <= link.countStrobe;
		end
	end
	assign loadFall  = loadPrev_q & ~link.loadStrobe;
	assign countFall = countPrev_q & ~link.countStrobe;

	// ********************************
	// Mode gating
	// ********************************
	always_comb begin
		cntNext = count_q;
		if (link.shiftSel) begin
			cntNext = {count_q[WIDTH-2:0], link.serialIn};
		end else begin
			case (mode)
				fbc_pkg::FBC_BIN_UP: begin
					cntNext = count_q + WIDTH'(1);
				end
				fbc_pkg::FBC_BIN_DOWN: begin
					cntNext = count_q - WIDTH'(1);
				end
				fbc_pkg::FBC_BCD_UP: begin
					cntNext = (count_q >= WIDTH'(`FBC_BCD_MAX)) ? WIDTH'(`FBC_ZERO)
						: count_q + WIDTH'(1);
				end
				fbc_pkg::FBC_BCD_DOWN: begin
					cntNext = (count_q == WIDTH'(`FBC_ZERO) || count_q > WIDTH'(`FBC_BCD_MAX))
						? WIDTH'(`FBC_BCD_MAX) : count_q - WIDTH'(1);
				end
				default: begin
					cntNext = count_q;
				end
			endcase
		end
	end

	// Set input per stage and the tick that clocks all stages together
	always_comb begin
		setIn     = count_q;
		stageTick = 1'b0;
		if (link.presetSel && loadFall) begin
			setIn     = link.presetData;
			stageTick = 1'b1;
		end else if (link.countQual && !link.presetSel && countFall) begin
			setIn     = cntNext;
			stageTick = 1'b1;
		end
	end

	// ********************************
	// Stages
	// ********************************
	// Erase acts synchronously at the next enabled edge regardless of strobes;
	// a truly clockless clear is not possible in a single-clock design.
	// Reset of every stage is wired true, so a clocked stage follows its set
	// input; set wins over reset, so a preset needs one-polarity data only.
	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= WIDTH'(`FBC_ZERO);
		end else if (clkEn) begin
			for (int i = 0; i < WIDTH; i++) begin
				if (link.erase) begin
					count_q[i] <= 1'b0;
				end else if (stageTick && setIn[i]) begin
					count_q[i] <= 1'b1;
				end else if (stageTick) begin
					count_q[i] <= 1'b0;
				end
			end
		end
	end

	assign link.count = count_q;
endmodule
`default_nettype wire

// File: design/fbc_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "fbc_defines.svh"
module fbc_controller (
	// System
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       clkEn,
	// User requests and status
	input  wire logic       presetReq,
	input  wire logic [3:0] presetValue,
	input  wire logic       countReq,
	input  wire logic       clearReq,
	input  wire logic [1:0] modeSel,
	input  wire logic       shiftEn,
	input  wire logic       serialData,
	output logic            busy,
	output logic [3:0]      countOut,
	// Link
	fbc_if.ctl              link
);
	typedef enum logic [1:0] {S_IDLE, S_HIGH, S_LOW} fbc_ctl_state_t;
	fbc_ctl_state_t state_q;
	logic           isPreset_q;
	logic [3:0]     data_q;
	logic           qual_q, sel_q, lstb_q, cstb_q, erase_q;

	// ********************************
	// Strobe sequencer
	// ********************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q    <= S_IDLE;
			isPreset_q <= 1'b0;
			data_q     <= 4'h0;
			qual_q     <= 1'b0;
			sel_q      <= 1'b0;
			lstb_q     <= 1'b0;
			cstb_q     <= 1'b0;
			erase_q    <= 1'b0;
			busy       <= 1'b0;
		end else if (clkEn) begin
			erase_q <= clearReq;
			case (state_q)
				S_IDLE: begin
					lstb_q <= 1'b0;
					cstb_q <= 1'b0;
					if (presetReq) begin
						qual_q     <= 1'b0;
						sel_q      <= 1'b1;
						data_q     <= presetValue;
						isPreset_q <= 1'b1;
						busy       <= 1'b1;
						state_q    <= S_HIGH;
					end else if (countReq) begin
						qual_q     <= 1'b1;
						sel_q      <= 1'b0;
						isPreset_q <= 1'b0;
						busy       <= 1'b1;
						state_q    <= S_HIGH;
					end else begin
						busy <= 1'b0;
					end
				end
				S_HIGH: begin
					// Strobe high one cycle, low at least two: under the 10 MHz ceiling
					lstb_q  <= isPreset_q;
					cstb_q  <= ~isPreset_q;
					state_q <= S_LOW;
				end
				S_LOW: begin
					lstb_q  <= 1'b0;
					cstb_q  <= 1'b0;
					state_q <= S_IDLE;
					busy    <= 1'b0;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			countOut <= 4'h0;
		end else if (clkEn) begin
			countOut <= link.count;
		end
	end

	assign link.presetData  = data_q;
	assign link.presetSel   = sel_q;
	assign link.loadStrobe  = lstb_q;
	assign link.countQual   = qual_q;
	assign link.countStrobe = cstb_q;
	assign link.shiftSel    = shiftEn;
	assign link.serialIn    = serialData;
	assign link.countMode   = modeSel;
	assign link.erase       = erase_q;
endmodule
`default_nettype wire

// File: sim/fbc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module fbc_assertions (
	// System and link
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [3:0] presetData,
	input wire logic       presetSel,
	input wire logic       loadStrobe,
	input wire logic       countQual,
	input wire logic       countStrobe,
	input wire logic       shiftSel,
	input wire logic       serialIn,
	input wire logic [1:0] countMode,
	input wire logic       erase,
	input wire logic [3:0] count
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence sLoad;
		presetSel && loadStrobe && !erase ##1 presetSel && !loadStrobe && !erase;
	endsequence
	sequence sStep(logic [1:0] m);
		countQual && !presetSel && !shiftSel && countMode == m && countStrobe && !erase
		##1 !countStrobe && !erase;
	endsequence
	AST_PRESET: assert property (sLoad |=> count == $past(presetData))
		else $error("preset not taken");
	AST_BIN_UP: assert property (sStep(2'h0) |=> count == $past(count) + 4'h1)
		else $error("binary up wrong");
	AST_BIN_DOWN: assert property (sStep(2'h1) |=> count == $past(count) - 4'h1)
		else $error("binary down wrong");
	AST_BCD_UP: assert property (sStep(2'h2) |=>
		count == (($past(count) >= 4'h9) ? 4'h0 : $past(count) + 4'h1)) else $error("bcd up wrong");
	AST_BCD_DOWN: assert property (sStep(2'h3) |=> count ==
		(($past(count) == 4'h0 || $past(count) > 4'h9) ? 4'h9 : $past(count) - 4'h1))
		else $error("bcd down wrong");
	AST_SHIFT: assert property (countQual && shiftSel && !presetSel && !erase &&
		$fell(countStrobe) |=> count == (($past(count) << 1) | $past(serialIn)))
		else $error("shift wrong");
	AST_ERASE: assert property (erase |=> count == 4'h0)
		else $error("erase ignored");
	AST_HOLD: assert property (!$fell(loadStrobe) && !$fell(countStrobe) && !erase
		|=> $stable(count)) else $error("count moved");
	AST_PRE_IDLE: assert property (presetSel |-> !countQual && !countStrobe)
		else $error("count active in preset");
	AST_PULSE: assert property ($rose(loadStrobe) || $rose(countStrobe)
		|=> !loadStrobe && !countStrobe) else $error("strobe too long");
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic       clk = 1'b0, rst = 1'b1, clkEn = 1'b1, presetReq = 1'b0, countReq = 1'b0;
	logic       clearReq = 1'b0, shiftEn = 1'b0, serialData = 1'b0, busy;
	logic [3:0] presetValue = 4'h0, countOut, expVal = 4'h0;
	logic [1:0] modeSel = 2'h0;
	int         fail_count = 0, cmp_count = 0, seed = 32'h901501d4, n;
	logic       hung = 1'b0;
	fbc_if link();
	always #20 clk = ~clk;
	fbc_counter i_fbc_counter (.clk(clk), .rst(rst), .clkEn(clkEn), .link(link.dev));
	fbc_controller i_fbc_controller (.clk(clk), .rst(rst), .clkEn(clkEn), .presetReq(presetReq),
		.presetValue(presetValue), .countReq(countReq), .clearReq(clearReq), .modeSel(modeSel),
		.shiftEn(shiftEn), .serialData(serialData), .busy(busy), .countOut(countOut),
		.link(link.ctl));
	fbc_assertions i_fbc_assertions (.clk(clk), .rst(rst), .presetData(link.presetData),
		.presetSel(link.presetSel), .loadStrobe(link.loadStrobe), .countQual(link.countQual),
		.countStrobe(link.countStrobe), .shiftSel(link.shiftSel), .serialIn(link.serialIn),
		.countMode(link.countMode), .erase(link.erase), .count(link.count));
	function automatic logic [3:0] nxt(logic [1:0] m, logic s, logic si, logic [3:0] c);
		if (s) return {c[2:0], si};
		case (m)
			2'h0: return c + 4'h1;
			2'h1: return c - 4'h1;
			2'h2: return (c >= 4'h9) ? 4'h0 : c + 4'h1;
			default: return (c == 4'h0 || c > 4'h9) ? 4'h9 : c - 4'h1;
		endcase
	endfunction
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(logic [3:0] e);
		cmp_count++;
		if (countOut !== e) begin
			fail_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, countOut);
		end
	endtask
	// Mode and shift inputs pass straight through, so hold them for the whole sequence
	task run(logic p, logic [3:0] v, logic [1:0] m, logic s, logic si);
		if (hung) return;
		@(posedge clk);
		presetReq <= p;
		countReq <= !p;
		presetValue <= v;
		modeSel <= m;
		shiftEn <= s;
		serialData <= si;
		@(posedge clk);
		presetReq <= 1'b0;
		countReq <= 1'b0;
		expVal = p ? v : nxt(m, s, si, expVal);
		n = 0;
		@(negedge clk);
		while (busy !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (busy !== 1'b0) begin
			fail_count++;
			hung = 1'b1;
		end else begin
			// countOut trails link.count by one register stage
			repeat (2) @(negedge clk);
			chk(expVal);
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		run(1'h1, 4'h9, 2'h0, 1'h0, 1'h0);
		run(1'h0, 4'h0, 2'h2, 1'h0, 1'h0);
		run(1'h0, 4'h0, 2'h3, 1'h0, 1'h0);
		run(1'h1, 4'hC, 2'h0, 1'h0, 1'h0);
		run(1'h0, 4'h0, 2'h3, 1'h0, 1'h0);
		run(1'h1, 4'hF, 2'h0, 1'h0, 1'h0);
		run(1'h0, 4'h0, 2'h0, 1'h0, 1'h0);
		run(1'h0, 4'h0, 2'h1, 1'h0, 1'h0);
		run(1'h0, 4'h0, 2'h1, 1'h1, 1'h0);
		@(posedge clk);
		clkEn <= 1'b0;
		clearReq <= 1'b1;
		repeat (3) @(posedge clk);
		clkEn <= 1'b1;
		clearReq <= 1'b0;
		@(negedge clk);
		chk(4'hE);
		@(posedge clk);
		clearReq <= 1'b1;
		@(posedge clk);
		clearReq <= 1'b0;
		repeat (3) @(negedge clk);
		expVal = 4'h0;
		chk(4'h0);
		repeat (40) run(1'($random(seed)), 4'($random(seed)), 2'($random(seed)),
			1'($random(seed)), 1'($random(seed)));
		summarize();
	end
endmodule
`default_nettype wire
